// File: common/sldc_pkg.sv
// Constants for the serial link deframer control block: register map,
// field positions, reset values, control characters and error limits.
// Assumes an 8-bit register port and one byte-wide decoded lane.
package sldc_pkg;
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   localparam int CNT_W = 4;

   // Register offsets
   localparam logic [ADDR_W-1:0] DEFRAMER_CONTROL_ZERO_ADDR = 12'h475;
   localparam logic [ADDR_W-1:0] DEFRAMER_CONTROL_ONE_ADDR = 12'h476;

   // Control zero fields
   localparam int RECEIVER_OFF_BIT = 7;
   localparam int END_CHAR_SUBST_OFF_BIT = 6;
   localparam int LINK_SOFT_RESET_BIT = 3;
   localparam int FORCE_RESYNC_BIT = 2;
   localparam int BAD_FRAME_SUBST_BIT = 0;

   // Control one fields
   localparam int DISPARITY_QUALIFY_BIT = 4;
   localparam int ALT_DESCR_START_BIT = 3;
   localparam int POST_SYNC_POLICY_BIT = 2;

   // Reset values
   localparam logic RECEIVER_OFF_RST = 1'h0;
   localparam logic END_CHAR_SUBST_OFF_RST = 1'h0;
   localparam logic LINK_SOFT_RESET_RST = 1'h0;
   localparam logic FORCE_RESYNC_RST = 1'h0;
   localparam logic BAD_FRAME_SUBST_RST = 1'h1;
   localparam logic DISPARITY_QUALIFY_RST = 1'h1;
   localparam logic ALT_DESCR_START_RST = 1'h0;
   localparam logic POST_SYNC_POLICY_RST = 1'h1;

   // Control characters (K codes)
   localparam logic [DATA_W-1:0] CHAR_R = 8'h1c;
   localparam logic [DATA_W-1:0] CHAR_A = 8'h7c;
   localparam logic [DATA_W-1:0] CHAR_K = 8'hbc;
   localparam logic [DATA_W-1:0] CHAR_F = 8'hfc;

   // Descrambling start octet for each setting
   localparam logic [1:0] DESCR_START_COMMON = 2'h0;
   localparam logic [1:0] DESCR_START_ALT = 2'h2;

   // Qualified disparity errors that raise a resync request
   localparam logic [CNT_W-1:0] DISPARITY_ERR_LIMIT = 4'h4;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;

   typedef enum logic [1:0] {
      SLDC_OFF,
      SLDC_WAIT_CGS,
      SLDC_SYNCED
   } sldc_phase_type;
endpackage

// File: design/sldc_deframer_ctrl.sv
// Deframer control registers and the per-character receive logic they steer:
// end-character substitution, bad-frame substitution, error qualification,
// descrambler start marking and the resync request toward the transmitter.
// Assumes lane inputs are decoded characters from logic on clk_sys.
// Operation
// R01: Character substitution off: end-of-frame and multiframe characters pass unchanged.
// R02: Software changes configuration only while soft reset is held.
// R03: Soft reset bit returns all deframer state to power-on values synchronously; the code clears only the datapath, control fields keep their values.
// R04: Soft reset stops reception of lane data.
// R05: Force bit asserts the resync request output.
// R06: Bad-frame enable replaces characters received in error; resets to one.
// R07: Qualify bit lets a not-in-table error mask a concurrent disparity error.
// R08: Alternative start bit moves descrambling start from octet 0 to octet 2.
// R09: Policy zero: after sync, request only on enough disparity errors.
// R10: Receiver-off bit disables the deframer receiver.
// R11: Policy one: after sync, K followed by non-R non-K requests resync.
// R12: Reserved bits read zero and ignore writes.
`timescale 1ns/1ps
module sldc_deframer_ctrl (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [sldc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [sldc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [sldc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic lane_valid,
   input wire logic [sldc_pkg::DATA_W-1:0] lane_data,
   input wire logic lane_is_k,
   input wire logic [1:0] lane_octet_idx,
   input wire logic lane_end_frame,
   input wire logic lane_end_mframe,
   input wire logic not_in_table_error,
   input wire logic lane_disparity_err,
   input wire logic cgs_done,
   output logic out_valid,
   output logic [sldc_pkg::DATA_W-1:0] out_data,
   output logic out_is_k,
   output logic out_nit_err,
   output logic out_disparity_err,
   output logic out_replaced,
   output logic out_descramble,
   output logic receiver_active,
   output logic resync_request_output
);

   typedef struct packed {
      logic receiver_off;
      logic end_character_substitution_off;
      logic link_soft_reset;
      logic force_resync_request;
      logic bad_frame_substitution_on;
      logic disparity_error_qualify;
      logic alt_descrambler_start;
      logic post_sync_error_policy;
      logic [sldc_pkg::DATA_W-1:0] rdata;
      sldc_pkg::sldc_phase_type phase;
      logic prev_k;
      logic [sldc_pkg::DATA_W-1:0] last_data;
      logic [sldc_pkg::CNT_W-1:0] err_cnt;
      logic sync_lat;
      logic o_valid;
      logic [sldc_pkg::DATA_W-1:0] o_data;
      logic o_is_k;
      logic o_nit;
      logic o_rd;
      logic o_repl;
      logic o_descr;
   } sldc_state_type;

   sldc_state_type st_r;
   sldc_state_type st_nxt;

   function automatic logic sldc_hit(input logic [sldc_pkg::ADDR_W-1:0] a,
                                     input logic [sldc_pkg::ADDR_W-1:0] b);
      sldc_hit = (a == b);
   endfunction

   function automatic logic sldc_is_char(input logic is_k,
                                         input logic [sldc_pkg::DATA_W-1:0] d,
                                         input logic [sldc_pkg::DATA_W-1:0] c);
      sldc_is_char = is_k && (d == c);
   endfunction

   logic rx_en;
   logic accept;
   logic rd_qual;
   logic lane_bad;
   logic end_char;
   logic k_break;
   logic [1:0] descr_start;

   // R04 reception stops in soft reset
   // R10 receiver off gate
   assign rx_en = !st_r.link_soft_reset && !st_r.receiver_off;
   assign accept = lane_valid && rx_en;
   // R07 not-in-table masks disparity
   assign rd_qual = lane_disparity_err && !(st_r.disparity_error_qualify && not_in_table_error);
   assign lane_bad = not_in_table_error || lane_disparity_err;
   assign end_char = (lane_end_frame && sldc_is_char(lane_is_k, lane_data, sldc_pkg::CHAR_F)) ||
                     (lane_end_mframe && sldc_is_char(lane_is_k, lane_data, sldc_pkg::CHAR_A));
   assign k_break = st_r.prev_k && !sldc_is_char(lane_is_k, lane_data, sldc_pkg::CHAR_K) &&
                    !sldc_is_char(lane_is_k, lane_data, sldc_pkg::CHAR_R);
   // R08 descrambling start octet
   assign descr_start = st_r.alt_descrambler_start ? sldc_pkg::DESCR_START_ALT :
                        sldc_pkg::DESCR_START_COMMON;

   always_comb begin
      st_nxt = st_r;
      st_nxt.rdata = '0;
      st_nxt.o_valid = 1'b0;
      st_nxt.o_nit = 1'b0;
      st_nxt.o_rd = 1'b0;
      st_nxt.o_repl = 1'b0;
      st_nxt.o_descr = 1'b0;

      // R12 reserved bits stay zero
      if (reg_wr && sldc_hit(reg_addr, sldc_pkg::DEFRAMER_CONTROL_ZERO_ADDR)) begin
         st_nxt.receiver_off = reg_wdata[sldc_pkg::RECEIVER_OFF_BIT];
         st_nxt.end_character_substitution_off = reg_wdata[sldc_pkg::END_CHAR_SUBST_OFF_BIT];
         st_nxt.link_soft_reset = reg_wdata[sldc_pkg::LINK_SOFT_RESET_BIT];
         st_nxt.force_resync_request = reg_wdata[sldc_pkg::FORCE_RESYNC_BIT];
         st_nxt.bad_frame_substitution_on = reg_wdata[sldc_pkg::BAD_FRAME_SUBST_BIT];
      end
      if (reg_wr && sldc_hit(reg_addr, sldc_pkg::DEFRAMER_CONTROL_ONE_ADDR)) begin
         st_nxt.disparity_error_qualify = reg_wdata[sldc_pkg::DISPARITY_QUALIFY_BIT];
         st_nxt.alt_descrambler_start = reg_wdata[sldc_pkg::ALT_DESCR_START_BIT];
         st_nxt.post_sync_error_policy = reg_wdata[sldc_pkg::POST_SYNC_POLICY_BIT];
      end
      if (reg_rd && sldc_hit(reg_addr, sldc_pkg::DEFRAMER_CONTROL_ZERO_ADDR)) begin
         st_nxt.rdata[sldc_pkg::RECEIVER_OFF_BIT] = st_r.receiver_off;
         st_nxt.rdata[sldc_pkg::END_CHAR_SUBST_OFF_BIT] = st_r.end_character_substitution_off;
         st_nxt.rdata[sldc_pkg::LINK_SOFT_RESET_BIT] = st_r.link_soft_reset;
         st_nxt.rdata[sldc_pkg::FORCE_RESYNC_BIT] = st_r.force_resync_request;
         st_nxt.rdata[sldc_pkg::BAD_FRAME_SUBST_BIT] = st_r.bad_frame_substitution_on;
      end
      if (reg_rd && sldc_hit(reg_addr, sldc_pkg::DEFRAMER_CONTROL_ONE_ADDR)) begin
         st_nxt.rdata[sldc_pkg::DISPARITY_QUALIFY_BIT] = st_r.disparity_error_qualify;
         st_nxt.rdata[sldc_pkg::ALT_DESCR_START_BIT] = st_r.alt_descrambler_start;
         st_nxt.rdata[sldc_pkg::POST_SYNC_POLICY_BIT] = st_r.post_sync_error_policy;
      end

      if (accept) begin
         st_nxt.o_valid = 1'b1;
         st_nxt.o_data = lane_data;
         st_nxt.o_is_k = lane_is_k;
         st_nxt.o_nit = not_in_table_error;
         st_nxt.o_rd = rd_qual;
         st_nxt.o_descr = (lane_octet_idx >= descr_start);
         // R06 bad character substitution
         if (st_r.bad_frame_substitution_on && lane_bad) begin
            st_nxt.o_data = st_r.last_data;
            st_nxt.o_is_k = 1'b0;
            st_nxt.o_repl = 1'b1;
         // R01 end-character substitution
         end else if (!st_r.end_character_substitution_off && end_char) begin
            st_nxt.o_data = st_r.last_data;
            st_nxt.o_is_k = 1'b0;
            st_nxt.o_repl = 1'b1;
         end
         st_nxt.last_data = st_nxt.o_data;
         st_nxt.prev_k = sldc_is_char(lane_is_k, lane_data, sldc_pkg::CHAR_K);
      end

      case (st_r.phase)
         sldc_pkg::SLDC_OFF: begin
            if (rx_en) begin
               st_nxt.phase = sldc_pkg::SLDC_WAIT_CGS;
            end
         end
         sldc_pkg::SLDC_WAIT_CGS: begin
            st_nxt.err_cnt = '0;
            st_nxt.sync_lat = 1'b0;
            if (cgs_done) begin
               st_nxt.phase = sldc_pkg::SLDC_SYNCED;
            end
         end
         sldc_pkg::SLDC_SYNCED: begin
            if (!cgs_done) begin
               st_nxt.phase = sldc_pkg::SLDC_WAIT_CGS;
            end else if (accept && !st_r.post_sync_error_policy && rd_qual) begin
               // R09 disparity error count
               if (st_r.err_cnt == sldc_pkg::DISPARITY_ERR_LIMIT - sldc_pkg::CNT_ONE) begin
                  st_nxt.sync_lat = 1'b1;
               end
               if (st_r.err_cnt != sldc_pkg::DISPARITY_ERR_LIMIT) begin
                  st_nxt.err_cnt = st_r.err_cnt + sldc_pkg::CNT_ONE;
               end
            end else if (accept && st_r.post_sync_error_policy && k_break) begin
               // R11 broken K sequence
               st_nxt.sync_lat = 1'b1;
            end
         end
         default: begin
            st_nxt.phase = sldc_pkg::SLDC_OFF;
         end
      endcase

      // R03 soft reset clears datapath
      // R10 receiver off also idles it
      if (!rx_en) begin
         st_nxt.phase = sldc_pkg::SLDC_OFF;
         st_nxt.prev_k = 1'b0;
         st_nxt.last_data = '0;
         st_nxt.err_cnt = '0;
         st_nxt.sync_lat = 1'b0;
         st_nxt.o_data = '0;
         st_nxt.o_is_k = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= '0;
         st_r.receiver_off <= sldc_pkg::RECEIVER_OFF_RST;
         st_r.end_character_substitution_off <= sldc_pkg::END_CHAR_SUBST_OFF_RST;
         st_r.link_soft_reset <= sldc_pkg::LINK_SOFT_RESET_RST;
         st_r.force_resync_request <= sldc_pkg::FORCE_RESYNC_RST;
         st_r.bad_frame_substitution_on <= sldc_pkg::BAD_FRAME_SUBST_RST;
         st_r.disparity_error_qualify <= sldc_pkg::DISPARITY_QUALIFY_RST;
         st_r.alt_descrambler_start <= sldc_pkg::ALT_DESCR_START_RST;
         st_r.post_sync_error_policy <= sldc_pkg::POST_SYNC_POLICY_RST;
         st_r.phase <= sldc_pkg::SLDC_OFF;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign reg_rdata = st_r.rdata;
   assign out_valid = st_r.o_valid;
   assign out_data = st_r.o_data;
   assign out_is_k = st_r.o_is_k;
   assign out_nit_err = st_r.o_nit;
   assign out_disparity_err = st_r.o_rd;
   assign out_replaced = st_r.o_repl;
   assign out_descramble = st_r.o_descr;
   assign receiver_active = rx_en;
   // R05 forced request
   // Request also stands while waiting for code group sync
   assign resync_request_output = st_r.force_resync_request || st_r.sync_lat ||
                                  (st_r.phase == sldc_pkg::SLDC_WAIT_CGS);

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   sequence k_seen;
      accept && st_r.phase == sldc_pkg::SLDC_SYNCED && cgs_done &&
      sldc_is_char(lane_is_k, lane_data, sldc_pkg::CHAR_K);
   endsequence
   sequence k_broken;
      accept && cgs_done && st_r.post_sync_error_policy &&
      !lane_is_k;
   endsequence

   a_char_pass_through: assert property ( // R01
      accept && st_r.end_character_substitution_off && !lane_bad && end_char
      |=> out_valid && out_data == $past(lane_data) && out_is_k && !out_replaced)
      else $error("end character altered while substitution off");
   a_soft_reset_clear: assert property ( // R03
      st_r.link_soft_reset |=> st_r.err_cnt == '0 && !st_r.sync_lat && !st_r.prev_k)
      else $error("soft reset left deframer state");
   a_soft_reset_quiet: assert property ( // R04
      st_r.link_soft_reset |=> !out_valid)
      else $error("data received during soft reset");
   a_force_sync_out: assert property ( // R05
      st_r.force_resync_request |-> resync_request_output)
      else $error("forced request not on output");
   a_bad_frame_subst: assert property ( // R06
      accept && st_r.bad_frame_substitution_on && lane_bad
      |=> out_replaced && out_data == $past(st_r.last_data))
      else $error("bad character not replaced");
   a_qualify_mask: assert property ( // R07
      accept && not_in_table_error && lane_disparity_err
      |=> out_disparity_err == !$past(st_r.disparity_error_qualify))
      else $error("disparity error qualification wrong");
   a_descr_start: assert property ( // R08
      accept |=> out_descramble ==
      ($past(lane_octet_idx) >= ($past(st_r.alt_descrambler_start) ? 2'h2 : 2'h0)))
      else $error("descrambling start octet wrong");
   a_err_limit_hit: assert property ( // R09
      accept && cgs_done && st_r.phase == sldc_pkg::SLDC_SYNCED &&
      !st_r.post_sync_error_policy && rd_qual && st_r.err_cnt == 4'h3
      |=> resync_request_output)
      else $error("disparity limit did not request resync");
   // The next write may lift receiver-off, so the gate is checked now and the output after
   a_rx_off_idle: assert property ( // R10
      st_r.receiver_off |-> !receiver_active ##1 !out_valid)
      else $error("receiver active while disabled");
   a_k_follow_sync: assert property ( // R11
      k_seen ##1 k_broken |=> resync_request_output [*2])
      else $error("broken K sequence did not request resync");
   a_resv_zero: assert property ( // R12
      reg_rd && sldc_hit(reg_addr, sldc_pkg::DEFRAMER_CONTROL_ZERO_ADDR)
      |=> reg_rdata[5:4] == 2'h0 && reg_rdata[1] == 1'b0)
      else $error("reserved bits read nonzero");
   a_resv_one_zero: assert property ( // R12
      reg_rd && !sldc_hit(reg_addr, sldc_pkg::DEFRAMER_CONTROL_ZERO_ADDR)
      |=> reg_rdata[7:5] == 3'h0 && reg_rdata[1:0] == 2'h0)
      else $error("reserved control one bits read nonzero");
   a_unmapped_read_zero: assert property ( // R12
      reg_rd && !sldc_hit(reg_addr, sldc_pkg::DEFRAMER_CONTROL_ZERO_ADDR) &&
      !sldc_hit(reg_addr, sldc_pkg::DEFRAMER_CONTROL_ONE_ADDR) |=> reg_rdata == '0)
      else $error("unmapped address read nonzero");

endmodule

// File: verif/sldc_framer_model.sv
// Transmitter-side lane model: hands one decoded character per put call.
// Assumes the deframer samples the lane on the rising edge of clk_sys.
`timescale 1ns/1ps
module sldc_framer_model (
   input wire logic clk_sys,
   output logic lane_valid,
   output logic [sldc_pkg::DATA_W-1:0] lane_data,
   output logic lane_is_k,
   output logic [1:0] lane_octet_idx,
   output logic lane_end_frame,
   output logic lane_end_mframe,
   output logic nit_err,
   output logic disp_err,
   output logic cgs_done
);
   initial begin
      lane_valid = 1'h0;
      lane_data = 8'h00;
      lane_is_k = 1'h0;
      lane_octet_idx = 2'h0;
      {lane_end_frame, lane_end_mframe, nit_err, disp_err} = 4'h0;
      cgs_done = 1'h0;
   end

   // Flags are {end of frame, end of multiframe, not in table, disparity}
   task automatic put(input logic [7:0] d, input logic k, input logic [1:0] idx,
      input logic [3:0] fl);
      @(posedge clk_sys);
      lane_valid <= 1'h1;
      lane_data <= d;
      lane_is_k <= k;
      lane_octet_idx <= idx;
      {lane_end_frame, lane_end_mframe, nit_err, disp_err} <= fl;
      @(posedge clk_sys);
      // Idle lane must not keep showing the last character
      lane_valid <= 1'h0;
      lane_data <= ~d;
      lane_is_k <= ~k;
      {lane_end_frame, lane_end_mframe, nit_err, disp_err} <= 4'h0;
   endtask

   // Two characters on consecutive cycles, with no idle cycle between them
   task automatic put2(input logic [7:0] d0, input logic k0, input logic [7:0] d1,
      input logic k1);
      @(posedge clk_sys);
      lane_valid <= 1'h1;
      lane_data <= d0;
      lane_is_k <= k0;
      lane_octet_idx <= 2'h0;
      {lane_end_frame, lane_end_mframe, nit_err, disp_err} <= 4'h0;
      @(posedge clk_sys);
      lane_data <= d1;
      lane_is_k <= k1;
      lane_octet_idx <= 2'h1;
      @(posedge clk_sys);
      lane_valid <= 1'h0;
      lane_data <= ~d1;
      lane_is_k <= ~k1;
   endtask

   task automatic link(input logic v);
      @(posedge clk_sys);
      cgs_done <= v;
   endtask
endmodule

// File: verif/tb_top.sv
// Self-checking bench for the deframer control block.
// Assumes the framer model drives the lane; registers via the plain port.
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'h0;
   logic arst_n = 1'h0;
   logic [sldc_pkg::ADDR_W-1:0] reg_addr = 12'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [7:0] reg_rdata, lane_data, out_data;
   logic [1:0] lane_octet_idx;
   logic lane_valid, lane_is_k, lane_end_frame, lane_end_mframe, nit_err, disp_err, cgs_done;
   logic out_valid, out_is_k, out_nit_err, out_disparity_err, out_replaced, out_descramble;
   logic receiver_active, resync_request_output;
   int miscompares = 0;
   int comparisons = 0;

   always #12.5 clk_sys = ~clk_sys;

   sldc_framer_model i_sldc_framer_model (.clk_sys, .lane_valid, .lane_data, .lane_is_k,
      .lane_octet_idx, .lane_end_frame, .lane_end_mframe, .nit_err, .disp_err, .cgs_done);

   sldc_deframer_ctrl i_sldc_deframer_ctrl (.clk_sys, .arst_n, .reg_addr, .reg_wdata,
      .reg_wr, .reg_rd, .reg_rdata, .lane_valid, .lane_data, .lane_is_k, .lane_octet_idx,
      .lane_end_frame, .lane_end_mframe, .not_in_table_error(nit_err),
      .lane_disparity_err(disp_err), .cgs_done, .out_valid, .out_data, .out_is_k,
      .out_nit_err, .out_disparity_err, .out_replaced, .out_descramble, .receiver_active,
      .resync_request_output);

   task automatic summarize();
      if (miscompares == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
      #1;
   endtask

   task automatic rd(input logic [11:0] a, input logic [7:0] e);
      @(posedge clk_sys);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1;
      chk("reg_rdata", e, reg_rdata);
   endtask

   // Settings change only while the soft reset is held, then it is released
   task automatic cfg(input logic [7:0] c0, input logic [7:0] c1);
      wr(12'h475, c0 | 8'h08);
      wr(12'h476, c1);
      wr(12'h475, c0);
      repeat (3) @(posedge clk_sys);
      #1;
   endtask

   task automatic p(input logic [7:0] d, input logic k, input logic [1:0] i, input logic [3:0] f);
      i_sldc_framer_model.put(d, k, i, f);
      #1;
   endtask

   task automatic co(input logic [7:0] d, input logic r);
      chk("out_valid", 8'h01, 8'(out_valid));
      chk("out_data", d, out_data);
      chk("out_replaced", {7'h0, r}, 8'(out_replaced));
   endtask

   task automatic rs(input logic e);
      chk("resync_request_output", {7'h0, e}, 8'(resync_request_output));
   endtask

   // Latched request may trail the character by a cycle or two
   task automatic wait_rs();
      int n;
      n = 0;
      while (resync_request_output !== 1'h1 && n < 6) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      rs(1'h1);
   endtask

   initial begin
      #(4000 * 25);
      miscompares++;
      summarize();
   end

   initial begin
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'h1;
      rd(12'h475, 8'h01);
      rd(12'h476, 8'h14);
      wr(12'h475, 8'h7f);
      rd(12'h475, 8'h4d);
      chk("receiver_active", 8'h00, 8'(receiver_active));
      p(8'h55, 1'h0, 2'h0, 4'h0);
      chk("out_valid", 8'h00, 8'(out_valid));
      wr(12'h476, 8'hff);
      rd(12'h476, 8'h1c);
      wr(12'h477, 8'hff);
      rd(12'h477, 8'h00);
      cfg(8'h80, 8'h10);
      rd(12'h475, 8'h80);
      chk("receiver_active", 8'h00, 8'(receiver_active));
      p(8'h55, 1'h0, 2'h0, 4'h0);
      chk("out_valid", 8'h00, 8'(out_valid));
      i_sldc_framer_model.link(1'h1);
      cfg(8'h01, 8'h10);
      rs(1'h0);
      wr(12'h475, 8'h05);
      rs(1'h1);
      wr(12'h475, 8'h01);
      rs(1'h0);
      p(8'h55, 1'h0, 2'h0, 4'h0);
      co(8'h55, 1'h0);
      chk("out_descramble", 8'h01, 8'(out_descramble));
      p(sldc_pkg::CHAR_F, 1'h1, 2'h3, 4'h8);
      co(8'h55, 1'h1);
      p(sldc_pkg::CHAR_A, 1'h1, 2'h3, 4'h4);
      co(8'h55, 1'h1);
      chk("out_is_k", 8'h00, 8'(out_is_k));
      p(8'h66, 1'h0, 2'h1, 4'h2);
      co(8'h55, 1'h1);
      chk("out_nit_err", 8'h01, 8'(out_nit_err));
      p(8'h77, 1'h0, 2'h1, 4'h3);
      chk("out_disparity_err", 8'h00, 8'(out_disparity_err));
      repeat (3) p(8'h33, 1'h0, 2'h0, 4'h1);
      chk("out_disparity_err", 8'h01, 8'(out_disparity_err));
      repeat (2) @(posedge clk_sys);
      #1;
      rs(1'h0);
      p(8'h33, 1'h0, 2'h0, 4'h1);
      wait_rs();
      cfg(8'h40, 8'h08);
      p(8'h55, 1'h0, 2'h0, 4'h0);
      chk("out_descramble", 8'h00, 8'(out_descramble));
      p(8'h12, 1'h0, 2'h2, 4'h0);
      chk("out_descramble", 8'h01, 8'(out_descramble));
      p(sldc_pkg::CHAR_F, 1'h1, 2'h3, 4'h8);
      co(sldc_pkg::CHAR_F, 1'h0);
      chk("out_is_k", 8'h01, 8'(out_is_k));
      p(8'h77, 1'h0, 2'h1, 4'h3);
      chk("out_disparity_err", 8'h01, 8'(out_disparity_err));
      cfg(8'h01, 8'h14);
      rs(1'h0);
      p(sldc_pkg::CHAR_F, 1'h1, 2'h3, 4'h8);
      co(8'h00, 1'h1);
      i_sldc_framer_model.put2(sldc_pkg::CHAR_K, 1'h1, sldc_pkg::CHAR_R, 1'h1);
      #1;
      co(sldc_pkg::CHAR_R, 1'h0);
      repeat (2) @(posedge clk_sys);
      #1;
      rs(1'h0);
      i_sldc_framer_model.put2(sldc_pkg::CHAR_K, 1'h1, 8'h55, 1'h0);
      #1;
      wait_rs();
      cfg(8'h01, 8'h14);
      rs(1'h0);
      p(sldc_pkg::CHAR_K, 1'h1, 2'h0, 4'h0);
      p(8'h55, 1'h0, 2'h1, 4'h0);
      wait_rs();
      summarize();
   end
endmodule
